/* File: shared/ivu_pkg.sv */
// Contract
// - fifteen sources, each with own vector
// - two nested levels; high never preempted
// - global gate low blocks every request
// - main enable bits 6..0 per source
// - extended enable: converter, port lines 8..2
// - enabled port lines wake from power-down
// - each port line has own polarity
// - port flag set by hardware, software clears
// - port level held one machine cycle
// - port request serviced next machine cycle
// - high level wins over simultaneous low
// - fixed polling order breaks equal ties
// - vector table 0003 to 0073 step 8
// - priority bit one means high level
// - polarity bit one means active high
// - flags 8..2 in bits 6..0, bit7 reserved
package ivu_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_EN_MAIN  = 8'ha8;
    localparam logic [7:0] ADDR_PRI_MAIN = 8'hb8;
    localparam logic [7:0] ADDR_FLAGS    = 8'hc0;
    localparam logic [7:0] ADDR_EN_EXT   = 8'he8;
    localparam logic [7:0] ADDR_POLARITY = 8'he9;
    localparam logic [7:0] ADDR_PRI_EXT  = 8'hf8;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam int         GATE_BIT      = 7;
    localparam int         CONV_BIT      = 7;
    localparam logic [7:0] FLAG_RSVD_MSK = 8'h7f;

    // ----------------------------------------------------------------
    // sources, numbered in vector order
    // ----------------------------------------------------------------
    localparam int N_SRC      = 15;
    localparam int N_FIXED    = 7;
    localparam int N_PORT     = 7;
    localparam int SRC_W      = 4;
    localparam int SRC_PORT0  = 7;
    localparam int SRC_CONV   = 14;

    localparam logic [15:0] VEC_BASE   = 16'h0003;
    localparam int          VEC_SHIFT  = 3;

    localparam int POLL_ORDER [N_SRC] =
        '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int MC_CLKS = 12;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ivu_sfr_req_t;

    typedef struct packed {
        logic             valid;
        logic             high;
        logic [SRC_W-1:0] src;
        logic [15:0]      addr;
    } ivu_vec_t;

endpackage

/* File: design/ivu_port_lines.sv */
`timescale 1ns/1ps
module ivu_port_lines
    import ivu_pkg::*;
#(
    parameter int N_LINES = N_PORT,
    parameter int HOLD    = MC_CLKS
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_resetn,
    input  wire logic [N_LINES-1:0] i_lines,
    input  wire logic [N_LINES-1:0] i_polarity,
    input  wire logic [N_LINES-1:0] i_enable,
    input  wire logic               i_mc_tick,
    input  wire logic               i_flag_we,
    input  wire logic [N_LINES-1:0] i_flag_wdata,
    output logic      [N_LINES-1:0] o_flags,
    output logic      [N_LINES-1:0] o_ripe,
    output logic      [N_LINES-1:0] o_wake
);

    localparam int CW = $clog2(HOLD + 1);

    genvar g;
    generate
        for (g = 0; g < N_LINES; g++) begin : g_line
            logic          meta_q;
            logic          sync_q;
            logic [CW-1:0] hold_q;
            logic          flag_q;
            logic          ripe_q;
            logic          active;
            logic          set;

            // ----------------------------------------------------
            // two-stage synchroniser
            // ----------------------------------------------------
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= i_lines[g];
                    sync_q <= meta_q;
                end
            end

            assign active = ~(sync_q ^ i_polarity[g]);
            assign set    = active & i_enable[g]
                          & (hold_q >= CW'(HOLD - 1));

            // ----------------------------------------------------
            // level hold counter, saturating
            // ----------------------------------------------------
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    hold_q <= '0;
                end else if (!active) begin
                    hold_q <= '0;
                end else if (hold_q != CW'(HOLD)) begin
                    hold_q <= hold_q + CW'(1);
                end
            end

            // ----------------------------------------------------
            // sticky flag, set beats software clear
            // ----------------------------------------------------
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    flag_q <= 1'b0;
                end else if (set) begin
                    flag_q <= 1'b1;
                end else if (i_flag_we) begin
                    flag_q <= i_flag_wdata[g];
                end
            end

            // flag becomes eligible at the next machine cycle
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    ripe_q <= 1'b0;
                end else if (!flag_q) begin
                    ripe_q <= 1'b0;
                end else if (i_mc_tick) begin
                    ripe_q <= 1'b1;
                end
            end

            assign o_flags[g] = flag_q;
            assign o_ripe[g]  = ripe_q & flag_q;
            assign o_wake[g]  = active & i_enable[g];
        end
    endgenerate

endmodule

/* File: design/ivu_irq_unit.sv */
`timescale 1ns/1ps
module ivu_irq_unit
    import ivu_pkg::*;
#(
    parameter int MC_LEN = MC_CLKS
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_resetn,
    input  wire ivu_sfr_req_t         i_sfr,
    input  wire logic [N_FIXED-1:0]   i_fixed_req,
    input  wire logic                 i_conv_req,
    input  wire logic [N_PORT-1:0]    i_port_line,
    input  wire logic                 i_insn_boundary,
    input  wire logic                 i_vec_ack,
    input  wire logic                 i_reti,
    output ivu_vec_t                  o_vec,
    output logic      [7:0]           o_sfr_rdata,
    output logic                      o_sfr_hit,
    output logic                      o_wake,
    output logic                      o_level_high,
    output logic                      o_level_low
);

    localparam int MCW = $clog2(MC_LEN);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0]         en_main_q;
    logic [7:0]         en_ext_q;
    logic [7:0]         pri_main_q;
    logic [7:0]         pri_ext_q;
    logic [7:0]         polarity_q;
    logic [MCW-1:0]     mc_cnt_q;
    logic               mc_tick_q;
    logic [N_PORT-1:0]  port_flags;
    logic [N_PORT-1:0]  port_ripe;
    logic [N_PORT-1:0]  port_wake;
    logic               flag_we;
    logic [N_SRC-1:0]   req_all;
    logic [N_SRC-1:0]   en_all;
    logic [N_SRC-1:0]   pri_all;
    logic [N_SRC-1:0]   pend;
    logic [N_SRC-1:0]   pend_hi;
    logic [N_SRC-1:0]   pend_lo;
    logic               gate;
    logic               win_any;
    logic               win_high;
    logic [SRC_W-1:0]   win_src;
    logic [SRC_W-1:0]   pick_hi;
    logic [SRC_W-1:0]   pick_lo;
    logic               hi_q;
    logic               lo_q;
    logic               hi_d;
    logic               lo_d;
    ivu_vec_t           vec_q;
    logic [7:0]         rdata_d;
    logic               hit_d;
    logic               wake_q;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            en_main_q <= RST_REG;
        end else if (i_sfr.wr && i_sfr.addr == ADDR_EN_MAIN) begin
            en_main_q <= i_sfr.wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            en_ext_q <= RST_REG;
        end else if (i_sfr.wr && i_sfr.addr == ADDR_EN_EXT) begin
            en_ext_q <= i_sfr.wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pri_main_q <= RST_REG;
        end else if (i_sfr.wr && i_sfr.addr == ADDR_PRI_MAIN) begin
            pri_main_q <= i_sfr.wdata & FLAG_RSVD_MSK;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pri_ext_q <= RST_REG;
        end else if (i_sfr.wr && i_sfr.addr == ADDR_PRI_EXT) begin
            pri_ext_q <= i_sfr.wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            polarity_q <= RST_REG;
        end else if (i_sfr.wr && i_sfr.addr == ADDR_POLARITY) begin
            polarity_q <= i_sfr.wdata & FLAG_RSVD_MSK;
        end
    end

    assign flag_we = i_sfr.wr && (i_sfr.addr == ADDR_FLAGS);

    // ----------------------------------------------------------------
    // machine cycle strobe
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            mc_cnt_q  <= '0;
            mc_tick_q <= 1'b0;
        end else if (mc_cnt_q == MCW'(MC_LEN - 1)) begin
            mc_cnt_q  <= '0;
            mc_tick_q <= 1'b1;
        end else begin
            mc_cnt_q  <= mc_cnt_q + MCW'(1);
            mc_tick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // port line qualification and flags
    // ----------------------------------------------------------------
    ivu_port_lines #(
        .N_LINES (N_PORT),
        .HOLD    (MC_LEN)
    ) u_port_lines (
        .i_clk_sys    (i_clk_sys),
        .i_resetn     (i_resetn),
        .i_lines      (i_port_line),
        .i_polarity   (polarity_q[N_PORT-1:0]),
        .i_enable     (en_ext_q[N_PORT-1:0]),
        .i_mc_tick    (mc_tick_q),
        .i_flag_we    (flag_we),
        .i_flag_wdata (i_sfr.wdata[N_PORT-1:0]),
        .o_flags      (port_flags),
        .o_ripe       (port_ripe),
        .o_wake       (port_wake)
    );

    // power-down wake from any enabled, active port line
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= |port_wake;
        end
    end

    // ----------------------------------------------------------------
    // source vectors in vector order
    // ----------------------------------------------------------------
    assign req_all = {i_conv_req, port_ripe, i_fixed_req};
    assign en_all  = {en_ext_q[CONV_BIT], en_ext_q[N_PORT-1:0],
                      en_main_q[N_FIXED-1:0]};
    assign pri_all = {pri_ext_q[CONV_BIT], pri_ext_q[N_PORT-1:0],
                      pri_main_q[N_FIXED-1:0]};
    assign gate    = en_main_q[GATE_BIT];

    assign pend    = gate ? (req_all & en_all) : '0;
    assign pend_hi = pend & pri_all;
    assign pend_lo = pend & ~pri_all;

    // ----------------------------------------------------------------
    // polling order search
    // ----------------------------------------------------------------
    function automatic logic [SRC_W-1:0] first_polled(
        input logic [N_SRC-1:0] m
    );
        logic [SRC_W-1:0] pick;
        logic             found;
        pick  = '0;
        found = 1'b0;
        for (int i = 0; i < N_SRC; i++) begin
            if (!found && m[POLL_ORDER[i]]) begin
                pick  = SRC_W'(POLL_ORDER[i]);
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    assign pick_hi = first_polled(pend_hi);
    assign pick_lo = first_polled(pend_lo);

    // ----------------------------------------------------------------
    // winner under the nesting state
    // ----------------------------------------------------------------
    always_comb begin
        win_any  = 1'b0;
        win_high = 1'b0;
        win_src  = '0;
        if (hi_q) begin
            win_any = 1'b0;
        end else if (|pend_hi) begin
            win_any  = 1'b1;
            win_high = 1'b1;
            win_src  = pick_hi;
        end else if (!lo_q && |pend_lo) begin
            win_any  = 1'b1;
            win_high = 1'b0;
            win_src  = pick_lo;
        end
    end

    // ----------------------------------------------------------------
    // vector offer to the core
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            vec_q <= '0;
        end else if (vec_q.valid) begin
            if (i_vec_ack) begin
                vec_q.valid <= 1'b0;
            end
        end else if (i_insn_boundary && win_any) begin
            vec_q.valid <= 1'b1;
            vec_q.high  <= win_high;
            vec_q.src   <= win_src;
            vec_q.addr  <= VEC_BASE
                         + (16'(win_src) << VEC_SHIFT);
        end
    end

    // ----------------------------------------------------------------
    // active level record
    // ----------------------------------------------------------------
    always_comb begin
        hi_d = hi_q;
        lo_d = lo_q;
        if (i_reti) begin
            if (hi_q) begin
                hi_d = 1'b0;
            end else begin
                lo_d = 1'b0;
            end
        end
        if (vec_q.valid && i_vec_ack) begin
            if (vec_q.high) begin
                hi_d = 1'b1;
            end else begin
                lo_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        hit_d   = 1'b1;
        case (i_sfr.addr)
            ADDR_EN_MAIN:  rdata_d = en_main_q;
            ADDR_EN_EXT:   rdata_d = en_ext_q;
            ADDR_PRI_MAIN: rdata_d = pri_main_q;
            ADDR_PRI_EXT:  rdata_d = pri_ext_q;
            ADDR_POLARITY: rdata_d = polarity_q;
            ADDR_FLAGS:    rdata_d = {1'b0, port_flags};
            default:       hit_d   = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sfr_rdata <= 8'h00;
            o_sfr_hit   <= 1'b0;
        end else if (i_sfr.rd) begin
            o_sfr_rdata <= rdata_d;
            o_sfr_hit   <= hit_d;
        end else begin
            o_sfr_hit   <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_vec        = vec_q;
    assign o_wake       = wake_q;
    assign o_level_high = hi_q;
    assign o_level_low  = lo_q;

endmodule

/* File: sim/ivu_assertions.sv */
`timescale 1ns/1ps
module ivu_assertions
    import ivu_pkg::*;
#(
    parameter int MC_LEN = MC_CLKS
) (
    input wire logic               i_clk_sys,
    input wire logic               i_resetn,
    input wire ivu_sfr_req_t       i_sfr,
    input wire logic [N_FIXED-1:0] i_fixed_req,
    input wire logic               i_conv_req,
    input wire logic [N_PORT-1:0]  i_port_line,
    input wire logic               i_insn_boundary,
    input wire logic               i_vec_ack,
    input wire logic               i_reti,
    input wire ivu_vec_t           o_vec,
    input wire logic [7:0]         o_sfr_rdata,
    input wire logic               o_sfr_hit,
    input wire logic               o_wake,
    input wire logic               o_level_high,
    input wire logic               o_level_low
);
    // ---------------------------------------------------------------
    // shadow of main enable, mapped-read decode
    // ---------------------------------------------------------------
    logic [7:0] en_q;
    logic       map_rd;

    assign map_rd = i_sfr.rd && i_sfr.addr inside {ADDR_EN_MAIN,
        ADDR_PRI_MAIN, ADDR_FLAGS, ADDR_EN_EXT, ADDR_POLARITY, ADDR_PRI_EXT};

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            en_q <= 8'h00;
        end else if (i_sfr.wr && i_sfr.addr == ADDR_EN_MAIN) begin
            en_q <= i_sfr.wdata;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    a_vec_addr_map: assert property (
        o_vec.valid |-> o_vec.addr == VEC_BASE + (16'(o_vec.src) << 3))
        else $error("vector address does not match source");
    a_offer_holds: assert property (
        o_vec.valid && !i_vec_ack |=> o_vec.valid && $stable(o_vec.addr))
        else $error("offer changed before ack");
    a_ack_clears: assert property (
        o_vec.valid && i_vec_ack |=> !o_vec.valid)
        else $error("offer stayed after ack");
    a_ack_level: assert property (
        o_vec.valid && i_vec_ack && !i_reti
        |=> ($past(o_vec.high) ? o_level_high : o_level_low))
        else $error("ack did not record level");
    a_high_no_nest: assert property (
        $rose(o_vec.valid) && !$past(i_reti) |-> !$past(o_level_high))
        else $error("offer while high routine runs");
    a_low_idle: assert property (
        $rose(o_vec.valid) && !o_vec.high && !$past(i_reti)
        |-> !$past(o_level_low))
        else $error("low offer while low routine runs");
    a_gate_blocks: assert property (
        $rose(o_vec.valid) |-> $past(en_q[GATE_BIT]))
        else $error("offer with global gate off");
    a_read_enable: assert property (
        i_sfr.rd && !i_sfr.wr && i_sfr.addr == ADDR_EN_MAIN
        |=> o_sfr_hit && o_sfr_rdata == $past(en_q))
        else $error("enable readback wrong");
    a_unmapped_rd: assert property (
        i_sfr.rd && !map_rd |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
        else $error("unmapped read answered");
    a_flag_rsvd: assert property (
        i_sfr.rd && i_sfr.addr == ADDR_FLAGS |=> !o_sfr_rdata[7])
        else $error("flag bit 7 read as one");
    a_reti_drops: assert property (
        i_reti && !i_vec_ack && o_level_high
        |=> !o_level_high && o_level_low == $past(o_level_low))
        else $error("return did not drop high level");

    c_nested: cover property (o_level_high && o_level_low);
    c_high_offer: cover property ($rose(o_vec.valid) && o_vec.high);
    c_wake: cover property (o_wake);
endmodule

/* File: sim/ivu_core_model.sv */
`timescale 1ns/1ps
module ivu_core_model
    import ivu_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire ivu_vec_t   i_vec,
    input  wire logic       i_run,
    input  wire logic [3:0] i_lat,
    input  wire logic       i_ret,
    output logic            o_boundary,
    output logic            o_ack,
    output logic            o_reti
);
    logic [3:0] wait_q;

    // ---------------------------------------------------------------
    // boundary every other cycle while running
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_boundary <= 1'b0;
            o_reti     <= 1'b0;
        end else begin
            o_boundary <= i_run & ~o_boundary;
            o_reti     <= i_ret;
        end
    end

    // ---------------------------------------------------------------
    // take the offer after a chosen delay
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ack  <= 1'b0;
            wait_q <= 4'h0;
        end else if (i_vec.valid && !o_ack && wait_q >= i_lat) begin
            o_ack  <= 1'b1;
            wait_q <= 4'h0;
        end else begin
            o_ack  <= 1'b0;
            wait_q <= i_vec.valid ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

/* File: sim/ivu_irq_unit_test.sv */
`timescale 1ns/1ps
module ivu_irq_unit_test
    import ivu_pkg::*;
;
    localparam int MC = 3;
    typedef struct packed {
        logic [31:0] regs;
        logic [6:0]  req;
        logic        conv;
        logic [15:0] addr;
        logic        hi;
    } ivu_row_t;
    localparam ivu_row_t ROWS [12] = '{
        '{32'h81000000, 7'h01, 1'b0, 16'h0003, 1'b0},
        '{32'hc0000000, 7'h40, 1'b0, 16'h0033, 1'b0},
        '{32'hff000000, 7'h7f, 1'b0, 16'h0003, 1'b0},
        '{32'hfe000000, 7'h7e, 1'b0, 16'h002b, 1'b0},
        '{32'hfe020000, 7'h7e, 1'b0, 16'h000b, 1'b1},
        '{32'hde000000, 7'h5e, 1'b0, 16'h000b, 1'b0},
        '{32'hd0000000, 7'h50, 1'b0, 16'h0033, 1'b0},
        '{32'h90000000, 7'h10, 1'b0, 16'h0023, 1'b0},
        '{32'h88000000, 7'h08, 1'b0, 16'h001b, 1'b0},
        '{32'h84000000, 7'h04, 1'b0, 16'h0013, 1'b0},
        '{32'h80008080, 7'h00, 1'b1, 16'h0073, 1'b1},
        '{32'h7f008000, 7'h7f, 1'b1, 16'h0000, 1'b0}};
    localparam logic [7:0] ADDRS [7] = '{ADDR_EN_MAIN, ADDR_PRI_MAIN,
        ADDR_FLAGS, ADDR_EN_EXT, ADDR_POLARITY, ADDR_PRI_EXT, 8'h10};

    logic         clk, rstn, conv, wake, lh, ll, bnd, ack, reti;
    logic         run, ret, got, vh, h;
    logic [3:0]   lat;
    logic [6:0]   fixed, port;
    logic [7:0]   rdata, d;
    logic [15:0]  va;
    ivu_sfr_req_t sfr;
    ivu_vec_t     vec;
    int           mismatches, num_checks;

    ivu_irq_unit #(.MC_LEN(MC)) uut (.i_clk_sys(clk), .i_resetn(rstn),
        .i_sfr(sfr), .i_fixed_req(fixed), .i_conv_req(conv),
        .i_port_line(port), .i_insn_boundary(bnd), .i_vec_ack(ack),
        .i_reti(reti), .o_vec(vec), .o_sfr_rdata(rdata), .o_sfr_hit(h),
        .o_wake(wake), .o_level_high(lh), .o_level_low(ll));
    ivu_core_model core (.i_clk_sys(clk), .i_resetn(rstn), .i_vec(vec),
        .i_run(run), .i_lat(lat), .i_ret(ret), .o_boundary(bnd),
        .o_ack(ack), .o_reti(reti));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        sfr = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        sfr = '0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        sfr = '0;
        d = rdata;
    endtask

    task automatic take();
        got = 1'b0;
        va = 16'h0;
        vh = 1'b0;
        run = 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(negedge clk);
            if (vec.valid === 1'b1) begin
                got = 1'b1;
                va = vec.addr;
                vh = vec.high;
            end
        end
        run = 1'b0;
        for (int n = 0; n < 20 && vec.valid !== 1'b0; n++) @(negedge clk);
        @(negedge clk);
        if (got) chk(16'(vh ? lh : ll), 16'h1);
    endtask

    task automatic ret_pulse();
        @(negedge clk);
        ret = 1'b1;
        @(negedge clk);
        ret = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #50000;
        mismatches++;
        conclude();
    end

    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        {rstn, conv, run, ret, lat, fixed} = '0;
        {sfr, mismatches, num_checks} = '0;
        port = 7'h7e;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        foreach (ADDRS[i]) begin
            rd(ADDRS[i]);
            chk({d, 7'h0, h}, {RST_REG, 7'h0, 1'(i < 6)});
        end
        wr(ADDR_POLARITY, 8'hff);
        rd(ADDR_POLARITY);
        chk(16'(d), 16'h007f);
        wr(ADDR_POLARITY, 8'h00);
        $display("register test done");
        foreach (ROWS[i]) begin
            lat = 4'(i % 4);
            wr(ADDR_PRI_MAIN, ROWS[i].regs[23:16]);
            wr(ADDR_PRI_EXT, ROWS[i].regs[7:0]);
            wr(ADDR_EN_EXT, ROWS[i].regs[15:8]);
            wr(ADDR_EN_MAIN, ROWS[i].regs[31:24]);
            fixed = ROWS[i].req;
            conv = ROWS[i].conv;
            take();
            chk(va, ROWS[i].addr);
            chk(16'(vh), 16'(ROWS[i].hi));
            fixed = '0;
            conv = 1'b0;
            ret_pulse();
        end
        $display("table test done");
        wr(ADDR_EN_EXT, 8'h00);
        wr(ADDR_PRI_EXT, 8'h00);
        wr(ADDR_PRI_MAIN, 8'h06);
        wr(ADDR_EN_MAIN, 8'h87);
        fixed = 7'h01;
        take();
        chk(va, 16'h0003);
        fixed = 7'h03;
        take();
        chk(va, 16'h000b);
        fixed = 7'h05;
        take();
        chk(16'(got), 16'h0);
        ret_pulse();
        take();
        chk(va, 16'h0013);
        fixed = '0;
        ret_pulse();
        ret_pulse();
        chk(16'({lh, ll}), 16'h0);
        $display("nesting test done");
        wr(ADDR_EN_MAIN, 8'h80);
        wr(ADDR_POLARITY, 8'h01);
        wr(ADDR_PRI_EXT, 8'h02);
        wr(ADDR_EN_EXT, 8'h03);
        port = 7'h7f;
        repeat (MC - 1) @(negedge clk);
        port = 7'h7e;
        repeat (10) @(negedge clk);
        rd(ADDR_FLAGS);
        chk(16'(d), 16'h0);
        port = 7'h7d;
        repeat (4) @(negedge clk);
        chk(16'(wake), 16'h1);
        repeat (2 * MC + 4) @(negedge clk);
        rd(ADDR_FLAGS);
        chk(16'(d), 16'h0003);
        port = 7'h7e;
        take();
        chk(va, 16'h0043);
        chk(16'(wake), 16'h0);
        wr(ADDR_FLAGS, 8'h01);
        ret_pulse();
        take();
        chk(va, 16'h003b);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS);
        chk(16'(d), 16'h0);
        ret_pulse();
        $display("port line test done");
        conclude();
    end
endmodule

bind ivu_irq_unit ivu_assertions #(.MC_LEN(MC_LEN)) chk_i (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_sfr(i_sfr),
    .i_fixed_req(i_fixed_req), .i_conv_req(i_conv_req),
    .i_port_line(i_port_line), .i_insn_boundary(i_insn_boundary),
    .i_vec_ack(i_vec_ack), .i_reti(i_reti), .o_vec(o_vec),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .o_wake(o_wake),
    .o_level_high(o_level_high), .o_level_low(o_level_low));
